// ===== dcpa_arbiter.sv
// two-channel dma priority arbiter and request pacing
// assumes the bus state controller times each unit and pulses unit_done
//
// Summary of operation
// - fixed mode: channel 0 pre-empts channel 1 burst
// - fixed mode: channel 0 burst finishes before channel 1 resumes
// - steal channel 0 interleaves unit-wise, bus kept
// - competing bursts, fixed mode: highest priority served first
// - bus held until all competing bursts done
// - cycle length set by bus controller as cpu
// - activation decided three bus cycles after request
// - first acknowledge at least six cycles after request
`timescale 1ns/10ps
module dcpa_arbiter #(
  parameter int ACK_MIN = dcpa_pkg::DCPA_ACK_MIN
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_prio_mode,
  input  wire dcpa_pkg::dcpa_chcfg_s i_cfg0,
  input  wire dcpa_pkg::dcpa_chcfg_s i_cfg1,
  input  wire logic [1:0]           i_transfer_request_in,
  input  wire logic                 i_unit_done,
  input  wire logic [1:0]           i_burst_last,
  output logic [1:0]                o_transfer_ack_out,
  output logic [1:0]                o_grant,
  output logic                      o_bus_own,
  output logic                      o_cfg_error
);

  initial begin
    if (ACK_MIN < dcpa_pkg::DCPA_DET_CYC + 1 || ACK_MIN > 15)
      $error("bad ACK_MIN");
  end

  logic [1:0]  act;
  logic [1:0]  act_clr;
  logic [1:0]  bmode;
  logic [1:0]  grant_r, grant_nxt;
  logic [1:0]  ack_r, ack_nxt;
  logic        own_r, own_nxt;
  logic        rr_last_r, rr_last_nxt;  // channel served last in rr
  logic        err_r;
  logic [3:0]  age_r [2];               // cycles since request seen
  logic [1:0]  pend;
  logic [1:0]  age_ok;
  logic        pick1;
  logic        last_srv;                // channel counted as served last
  logic        have;
  dcpa_pkg::dcpa_state_e st_r, st_nxt;

  assign bmode = {i_cfg1.bus_mode, i_cfg0.bus_mode};

  // activation detector for each request line
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_det
      dcpa_req_detect #(.DET_CYC(dcpa_pkg::DCPA_DET_CYC)) u_det (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_req     (i_transfer_request_in[g]
                    & (g == 0 ? i_cfg0.enable : i_cfg1.enable)),
        .i_clr     (act_clr[g]),
        .o_active  (act[g])
      );
      // first acknowledge never earlier than ACK_MIN after request
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n)
          age_r[g] <= 4'h0;
        else if (!i_transfer_request_in[g])
          age_r[g] <= 4'h0;
        else if (age_r[g] != 4'hF)
          age_r[g] <= age_r[g] + 4'h1;
      end
      assign age_ok[g] = (age_r[g] >= 4'(ACK_MIN - 1));
    end
  endgenerate

  assign act_clr = grant_r & {2{i_unit_done}} & i_burst_last;
  // a channel on its last unit is no longer pending, or it gets an extra unit
  assign pend    = act & age_ok & ~act_clr;
  assign have    = |pend;

  // the channel finishing a unit right now is the one served last
  assign last_srv = (st_r == dcpa_pkg::DCPA_XFER && i_unit_done) ?
                    grant_r[1] : rr_last_r;

  // fixed: ch0 wins at once; rr: the last-served channel loses a tie
  assign pick1 = !pend[0] ||
                 (i_prio_mode == dcpa_pkg::DCPA_MODE_RR &&
                  pend[1] && !last_srv);

  // selection for the next unit boundary
  always_comb begin
    st_nxt      = st_r;
    grant_nxt   = grant_r;
    ack_nxt     = 2'b00;
    own_nxt     = own_r;
    rr_last_nxt = rr_last_r;
    case (st_r)
      dcpa_pkg::DCPA_IDLE: begin
        if (have) begin
          st_nxt    = dcpa_pkg::DCPA_XFER;
          grant_nxt = pick1 ? 2'b10 : 2'b01;
          ack_nxt   = grant_nxt;
          own_nxt   = 1'b1;
        end
      end
      dcpa_pkg::DCPA_XFER: begin
        ack_nxt = grant_r;
        // unit length comes from the bus controller, not counted here
        if (i_unit_done) begin
          rr_last_nxt = grant_r[1];
          if (have) begin
            // pre-empt / interleave at each unit boundary
            grant_nxt = pick1 ? 2'b10 : 2'b01;
            ack_nxt   = grant_nxt;
          end else begin
            st_nxt    = dcpa_pkg::DCPA_IDLE;
            grant_nxt = 2'b00;
            ack_nxt   = 2'b00;
            own_nxt   = 1'b0;
          end
        end
      end
      default: begin
        st_nxt    = dcpa_pkg::DCPA_IDLE;
        grant_nxt = 2'b00;
        own_nxt   = 1'b0;
      end
    endcase
  end

  // state and outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r      <= dcpa_pkg::DCPA_IDLE;
      grant_r   <= 2'b00;
      ack_r     <= 2'b00;
      own_r     <= 1'b0;
      rr_last_r <= 1'b0;
      err_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      grant_r   <= grant_nxt;
      ack_r     <= ack_nxt;
      own_r     <= own_nxt;
      rr_last_r <= rr_last_nxt;
      // flags the unsupported steal/burst mix in round-robin
      err_r     <= (i_prio_mode == dcpa_pkg::DCPA_MODE_RR) &&
                   i_cfg0.enable && i_cfg1.enable &&
                   (bmode[0] != bmode[1]);
    end
  end

  assign o_transfer_ack_out = ack_r;
  assign o_grant            = grant_r;
  assign o_bus_own          = own_r;
  assign o_cfg_error        = err_r;

  // checks
  sequence s_ch0_ready;
    pend[0] && i_prio_mode == dcpa_pkg::DCPA_MODE_FIXED;
  endsequence

  chk_fixed_preempt: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_r == dcpa_pkg::DCPA_XFER && i_unit_done) ##0 s_ch0_ready
      |=> grant_r == 2'b01)
    else $error("channel 0 did not pre-empt");

  chk_burst_order: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (grant_r == 2'b01 && pend[0] && !i_prio_mode) |=> !grant_r[1])
    else $error("channel 1 resumed during channel 0 burst");

  chk_steal_keep: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (grant_r == 2'b01 && i_unit_done && pend[1] && !pend[0])
      |=> grant_r == 2'b10 && own_r)
    else $error("bus not kept for channel 1 after steal");

  chk_high_first: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_r == dcpa_pkg::DCPA_IDLE && pend == 2'b11 && !i_prio_mode)
      |=> grant_r == 2'b01)
    else $error("lower channel served first");

  chk_bus_held: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (own_r && have) |=> own_r)
    else $error("bus released while requests compete");

  chk_unit_len: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_r == dcpa_pkg::DCPA_XFER && !i_unit_done) |=> $stable(grant_r))
    else $error("grant moved inside a bus cycle");

  chk_ack_min: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(i_transfer_request_in[0]) ##1
      (i_transfer_request_in[0] && !o_transfer_ack_out[0])[*4]
      |=> !o_transfer_ack_out[0])
    else $error("acknowledge earlier than six cycles");

  chk_rr_rotate: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_prio_mode && grant_r == 2'b01 && i_unit_done && pend == 2'b11)
      |=> grant_r == 2'b10)
    else $error("round-robin did not rotate");

  chk_cfg_mix: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_prio_mode && i_cfg0.enable && i_cfg1.enable &&
     i_cfg0.bus_mode != i_cfg1.bus_mode) |=> o_cfg_error)
    else $error("mixed mode not flagged");

endmodule // dcpa_arbiter

// ===== dcpa_far_dev.sv
// far-side model: request source plus unit pacing of the bus controller
// assumes ack is one-hot and follows the grant of the arbiter
`timescale 1ns/10ps
module dcpa_far_dev (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_slow,
  input  wire logic [1:0] i_go,
  input  wire logic [3:0] i_len,
  input  wire logic [1:0] i_ack,
  output logic [1:0]      o_req,
  output logic [1:0]      o_last,
  output logic            o_done
);
  logic [3:0] left_r [2];
  logic [1:0] wait_r;
  logic       ch;
  assign ch = i_ack[1];
  // go loads a unit count; the request drops with its last unit
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left_r <= '{4'h0, 4'h0};
      wait_r <= 2'h0;
      o_req  <= 2'h0;
      o_last <= 2'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_last <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        if (i_go[c]) begin
          left_r[c] <= i_len;
          o_req[c]  <= 1'b1;
        end
      end
      // skip the edge where done is still seen, so no unit counts twice
      if (!o_done && |i_ack) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r == {i_slow, i_slow}) begin
          wait_r     <= 2'h0;
          o_done     <= 1'b1;
          left_r[ch] <= left_r[ch] - 4'h1;
          o_last[ch] <= (left_r[ch] == 4'h1);
          if (left_r[ch] == 4'h1)
            o_req[ch] <= 1'b0;
        end
      end
    end
  end
endmodule // dcpa_far_dev

// ===== dcpa_pkg.sv
// package for the two-channel dma priority arbiter
// assumes one bus clock domain; no software registers
package dcpa_pkg;

  // time figures in bus clock cycles
  localparam int DCPA_DET_CYC   = 3;  // request sampling to activation
  localparam int DCPA_ACK_MIN   = 6;  // request sampling to first ack
  localparam int DCPA_CNT_W     = 4;

  localparam logic DCPA_MODE_FIXED = 1'b0;
  localparam logic DCPA_MODE_RR    = 1'b1;
  localparam logic DCPA_BUS_STEAL  = 1'b0;
  localparam logic DCPA_BUS_BURST  = 1'b1;

  // per-channel configuration, as held in channel_control_reg
  typedef struct packed {
    logic enable;     // channel armed
    logic bus_mode;   // burst or cycle steal
    logic ack_timing_select;
  } dcpa_chcfg_s;

  typedef enum logic [1:0] {
    DCPA_IDLE = 2'b00,
    DCPA_DET  = 2'b01,
    DCPA_XFER = 2'b10
  } dcpa_state_e;

endpackage

// ===== dcpa_req_detect.sv
// request detector: activation decision after a fixed count
// assumes transfer_request_in is synchronous to the bus clock
`timescale 1ns/10ps
module dcpa_req_detect #(
  parameter int DET_CYC = dcpa_pkg::DCPA_DET_CYC
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_req,
  input  wire logic i_clr,
  output logic      o_active
);

  logic [3:0] cnt_r;
  logic       act_r;

  initial begin
    if (DET_CYC < 1 || DET_CYC > 15) $error("bad DET_CYC");
  end

  // requests held for DET_CYC edges become an activation
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 4'h0;
      act_r <= 1'b0;
    end else if (i_clr || !i_req) begin
      cnt_r <= 4'h0;
      act_r <= 1'b0;
    end else if (cnt_r == 4'(DET_CYC - 1)) begin
      act_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign o_active = act_r;

endmodule // dcpa_req_detect

// ===== test_dcpa_arbiter.sv
// self-checking bench for the two-channel arbiter
// assumes dcpa_far_dev paces units and raises the requests
`timescale 1ns/10ps
module test_dcpa_arbiter;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  mode = 1'b0;
  logic                  slow = 1'b1;
  logic                  hold = 1'b0;
  logic [1:0]            go = 2'h0;
  logic [3:0]            len;
  dcpa_pkg::dcpa_chcfg_s cfg0 = '{1'b1, dcpa_pkg::DCPA_BUS_BURST, 1'b0};
  dcpa_pkg::dcpa_chcfg_s cfg1 = '{1'b1, dcpa_pkg::DCPA_BUS_BURST, 1'b0};
  logic [1:0]            req, last, ack, grant, prev;
  logic                  done, own, cfg_err;
  logic [1:0]            exp_q [$];
  int                    n_errors = 0;
  int                    checks_done = 0;
  int                    seed = 32'h0AD64D38;
  int                    k;
  always #2.5 clk = ~clk;
  dcpa_arbiter i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_prio_mode(mode),
    .i_cfg0(cfg0), .i_cfg1(cfg1), .i_transfer_request_in(req),
    .i_unit_done(done), .i_burst_last(last), .o_transfer_ack_out(ack),
    .o_grant(grant), .o_bus_own(own), .o_cfg_error(cfg_err));
  dcpa_far_dev i_far (.i_sys_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
    .i_go(go), .i_len(len), .i_ack(ack), .o_req(req), .o_last(last),
    .o_done(done));
  task automatic cmp_grant(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic start(input logic [1:0] ch, input logic [3:0] n);
    @(posedge clk);
    go  <= ch;
    len <= n;
    @(posedge clk);
    go  <= 2'h0;
  endtask
  // bounded waits; a wait that reaches its bound of 200 or 300 cycles counts an error itself
  task automatic wait_g(input logic [1:0] g);
    k = 0;
    while (grant !== g && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) n_errors++;
  endtask
  task automatic idle();
    k = 0;
    while ((own !== 1'b0 || req !== 2'h0) && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (k == 300) n_errors++;
  endtask
  // grant changes are settled by the falling edge
  always @(negedge clk) begin
    if (rst_n && grant !== prev && grant !== 2'h0)
      cmp_grant(grant, exp_q.size() ? exp_q.pop_front() : 2'h0);
    if (hold && req[1])
      cmp_bit(own, 1'b1);
    prev = grant;
  end
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cfg1.ack_timing_select <= 1'($random(seed));
    exp_q.push_back(2'h1);
    start(2'h1, 4'h1);
    k = 0;
    while (ack === 2'h0 && k < 30) begin
      @(negedge clk);
      k++;
    end
    cmp_bit(k >= 6 && k < 30, 1'b1);
    idle();
    // pass 0: ch0 burst pre-empts; pass 1: ch0 steals single units
    for (int s = 0; s < 2; s++) begin
      exp_q.push_back(2'h2);
      start(2'h2, 4'h8 + 4'($random(seed) & 3));
      wait_g(2'h2);
      for (int r = 0; r <= s; r++) begin
        exp_q.push_back(2'h1);
        exp_q.push_back(2'h2);
        start(2'h1, s ? 4'h1 : 4'h2);
        wait_g(2'h1);
        hold = 1'b1;
        wait_g(2'h2);
      end
      idle();
      hold = 1'b0;
    end
    // disabled channel is refused; then both channels raise at once
    @(posedge clk);
    cfg1.enable <= 1'b0;
    slow        <= 1'($random(seed));
    start(2'h2, 4'h1);
    repeat (12) @(negedge clk);
    cmp_bit(own, 1'b0);
    @(posedge clk);
    cfg1.enable <= 1'b1;
    exp_q.push_back(2'h2);
    idle();
    exp_q.push_back(2'h1);
    exp_q.push_back(2'h2);
    start(2'h3, 4'h2);
    wait_g(2'h1);
    idle();
    // round-robin with like modes on both channels
    @(posedge clk);
    mode <= dcpa_pkg::DCPA_MODE_RR;
    for (int r = 0; r < 2; r++) begin
      exp_q.push_back(2'h1);
      exp_q.push_back(2'h2);
    end
    start(2'h1, 4'h2);
    start(2'h2, 4'h2);
    idle();
    cmp_bit(cfg_err, 1'b0);
    @(posedge clk);
    cfg0.bus_mode <= dcpa_pkg::DCPA_BUS_STEAL;
    repeat (3) @(negedge clk);
    cmp_bit(cfg_err, 1'b1);
    cmp_bit(exp_q.size() == 0, 1'b1);
    results();
  end
endmodule // test_dcpa_arbiter
